//--- dv/rsc_sys_model.sv
// Far side: external reset source and receiver of system reset.
// Assumes one pclk domain; the pin idles high through its pull-up.
`timescale 1ns/1ps
module rsc_sys_model (
  // Request from bench
  input  wire logic       hold_req,
  // Reset seen by system logic
  input  wire logic       system_reset_n,
  // Pin and reset count
  output logic            external_reset_pin_n,
  output logic [7:0]      rst_count
);
  // Pin pulled low while held, pulled up otherwise
  assign external_reset_pin_n = !hold_req;
  // Count each entry into system reset, skipping power-up settling
  initial rst_count = 8'h00;
  always @(negedge system_reset_n)
    if ($time > 0)
      rst_count <= rst_count + 8'h01;
endmodule

//--- dv/rsc_top_asserts.sv
// Port checker of the reset source controller.
// Bound into rsc_top; one pclk domain, async low presetn.
`timescale 1ns/1ps
module rsc_top_asserts (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Sources and mode
  input wire logic                 external_reset_pin_n,
  input wire logic                 supply_below_trip,
  input wire logic                 digital_supply_stable,
  input wire logic                 low_power_mode,
  input wire rsc_pkg::rsc_supply_t supply_cmp,
  // Outputs watched
  input wire logic                 system_reset_n,
  input wire logic                 por_monitor_enable,
  input wire logic                 main_oscillator_enable,
  input wire logic                 monitor_enable,
  input wire rsc_pkg::rsc_supply_t supply_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Source seen, then reset held two cycles
  sequence s_ext; !external_reset_pin_n; endsequence
  sequence s_por; supply_below_trip; endsequence
  sequence s_held; !system_reset_n [*2]; endsequence
  chk_ext_holds: assert property (s_ext |=> s_held)
    else $error("ext pin low without held reset");
  chk_por_holds: assert property (s_por |=> s_held)
    else $error("supply trip without held reset");
  chk_por_mon: assert property (supply_below_trip |=>
    por_monitor_enable && !main_oscillator_enable)
    else $error("monitor or oscillator wrong in trip");
  chk_por_off: assert property (presetn && digital_supply_stable &&
    !supply_below_trip |=> !por_monitor_enable && main_oscillator_enable)
    else $error("monitor or oscillator wrong when stable");
  chk_pulse_min: assert property ($rose(system_reset_n) |->
    $past(system_reset_n, 2) == 1'b0)
    else $error("reset pulse too short");
  chk_irq_idle: assert property (low_power_mode || !monitor_enable |=>
    supply_irq == rsc_pkg::SUPPLY_NONE)
    else $error("interrupt while monitors off");
  chk_irq_follow: assert property (monitor_enable && !low_power_mode |=>
    supply_irq == $past(supply_cmp))
    else $error("interrupt does not follow comparators");
  chk_mon_gate: assert property (supply_below_trip |=>
    !monitor_enable)
    else $error("monitors run in power-on reset");
  chk_trip_rst: assert property (supply_below_trip |=>
    !system_reset_n ##1 !system_reset_n)
    else $error("system reset missing in trip");
endmodule
bind rsc_top rsc_top_asserts u_rsc_top_asserts (.pclk(pclk),
  .presetn(presetn), .external_reset_pin_n(external_reset_pin_n),
  .supply_below_trip(supply_below_trip), .supply_cmp(supply_cmp),
  .digital_supply_stable(digital_supply_stable),
  .low_power_mode(low_power_mode), .system_reset_n(system_reset_n),
  .por_monitor_enable(por_monitor_enable), .supply_irq(supply_irq),
  .main_oscillator_enable(main_oscillator_enable),
  .monitor_enable(monitor_enable));

//--- dv/tb.sv
// Self-checking bench of the reset source controller.
// Drives APB, supplies and the pin model; 10 MHz pclk.
`timescale 1ns/1ps
module tb;
  // Bench signals
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pclk, presetn, psel, penable, pwrite, pready, err, rerr;
  logic        trip, dss, lpm, hold, pin_n, sys_n, pmon, osc, mon;
  logic [3:0]  ana, dig;
  logic [7:0]  rcnt;
  rsc_pkg::rsc_supply_t cmp, irq;
  int          bad_count, n_checks;
  // Block and far side
  rsc_top #(.HOLD_CYC(1)) u_rsc_top (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
    .supply_below_trip(trip), .digital_supply_stable(dss),
    .low_power_mode(lpm), .supply_cmp(cmp), .external_reset_pin_n(pin_n),
    .system_reset_n(sys_n), .por_monitor_enable(pmon),
    .main_oscillator_enable(osc), .monitor_enable(mon),
    .ana_trip_sel(ana), .dig_trip_sel(dig), .supply_irq(irq));
  rsc_sys_model u_rsc_sys_model (.hold_req(hold), .system_reset_n(sys_n),
    .external_reset_pin_n(pin_n), .rst_count(rcnt));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer after an idle edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      bad_count++;
      complete_run();
    end
    rd = prdata;
    rerr = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Wait for reset release, counting low cycles
  task automatic wait_rel(output int n);
    n = 0;
    while (sys_n !== 1'b1)
    begin
      @(posedge pclk);
      #1;
      n++;
      if (n > 200)
      begin
        bad_count++;
        complete_run();
      end
    end
  endtask
  // Power-up state and unmapped access
  task automatic t_por();
    int n;
    wait_rel(n);
    chk(32'(osc), 32'h1);
    chk(32'(pmon), 32'h0);
    rdc(rsc_pkg::CAUSE_ADDR, 32'h1);
    rdc(rsc_pkg::WDT_ADDR, 32'hFFFF);
    rdc(rsc_pkg::CTRL_ADDR, 32'h0);
    rdc(12'h020, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("done por");
  endtask
  // Software reset, then blocked command
  task automatic t_sw();
    int n;
    logic [7:0] c0;
    wr(rsc_pkg::CTRL_ADDR, 32'h1);
    #1;
    chk(32'(sys_n), 32'h0);
    wait_rel(n);
    chk(32'(n), 32'h2);
    rdc(rsc_pkg::CAUSE_ADDR, 32'h4);
    c0 = rcnt;
    wr(rsc_pkg::CTRL_ADDR, 32'h2);
    wr(rsc_pkg::CTRL_ADDR, 32'h3);
    repeat (3) @(posedge pclk);
    chk(32'(rcnt), 32'(c0));
    rdc(rsc_pkg::CAUSE_ADDR, 32'h4);
    wr(rsc_pkg::CTRL_ADDR, 32'h0);
    $display("done sw");
  endtask
  // External pin held low in low-power mode
  task automatic t_ext();
    int n;
    @(posedge pclk);
    hold <= 1'b1;
    lpm <= 1'b1;
    repeat (6)
    begin
      @(posedge pclk);
      #1;
      chk(32'(sys_n), 32'h0);
    end
    @(posedge pclk);
    hold <= 1'b0;
    lpm <= 1'b0;
    wait_rel(n);
    rdc(rsc_pkg::CAUSE_ADDR, 32'h2);
    $display("done ext");
  endtask
  // Trip codes, interrupts and low-power gating
  task automatic t_mon();
    for (int i = 0; i < 13; i++)
    begin
      wr(rsc_pkg::MONCFG_ADDR, 32'h100 | 32'(i) | 32'(i << 4));
      @(posedge pclk);
      #1;
      chk(32'(ana), 32'(i));
      chk(32'(dig), 32'(i));
    end
    wr(rsc_pkg::MONCFG_ADDR, 32'h1DC);
    @(posedge pclk);
    #1;
    chk(32'(dig), 32'hC);
    chk(32'(ana), 32'hC);
    @(posedge pclk);
    cmp <= 3'h5;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h5);
    rdc(rsc_pkg::MONST_ADDR, 32'h0D);
    @(posedge pclk);
    lpm <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
    // Wake up: interrupts follow the comparators again two cycles later
    @(posedge pclk);
    lpm <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h5);
    $display("done mon");
  endtask
  // Watchdog enable, kicks, expiry and freeze
  task automatic t_wdt();
    int n;
    logic [7:0] c0;
    @(posedge pclk);
    lpm <= 1'b0;
    cmp <= 3'h0;
    wr(rsc_pkg::WDT_ADDR, 32'h14);
    wr(rsc_pkg::CTRL_ADDR, 32'h4);
    wr(rsc_pkg::CTRL_ADDR, 32'h0);
    rdc(rsc_pkg::CTRL_ADDR, 32'h4);
    c0 = rcnt;
    repeat (5) wr(rsc_pkg::CTRL_ADDR, 32'hC);
    chk(32'(rcnt), 32'(c0));
    n = 0;
    while (sys_n === 1'b1 && n < 60)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n >= 20 && n <= 23), 32'h1);
    wait_rel(n);
    @(posedge pclk);
    lpm <= 1'b1;
    c0 = rcnt;
    repeat (40) @(posedge pclk);
    chk(32'(rcnt), 32'(c0));
    rdc(rsc_pkg::CAUSE_ADDR, 32'h8);
    $display("done wdt");
  endtask
  // Supply trip acts as power-on reset
  task automatic t_trip();
    int n;
    logic [7:0] c0;
    @(posedge pclk);
    trip <= 1'b1;
    dss <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(sys_n), 32'h0);
    chk(32'(pmon), 32'h1);
    chk(32'(osc), 32'h0);
    chk(32'(mon), 32'h0);
    @(posedge pclk);
    trip <= 1'b0;
    dss <= 1'b1;
    lpm <= 1'b0;
    wait_rel(n);
    c0 = rcnt;
    rdc(rsc_pkg::CAUSE_ADDR, 32'h1);
    rdc(rsc_pkg::CTRL_ADDR, 32'h0);
    rdc(rsc_pkg::MONCFG_ADDR, 32'h0);
    repeat (40) @(posedge pclk);
    chk(32'(rcnt), 32'(c0));
    $display("done trip");
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, trip, lpm, hold} = 7'h00;
    {paddr, pwdata, cmp, dss} = {12'h000, 32'h0, 3'h0, 1'b1};
    {bad_count, n_checks} = {32'h0, 32'h0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_sw();
    t_ext();
    t_mon();
    t_wdt();
    t_trip();
    complete_run();
  end
endmodule

//--- src/rsc_pkg.sv
// Constants, register map and carrier types of the reset source controller.
// Assumes a 10 MHz APB clock; shared by the design and the bench.
package rsc_pkg;

  // Clock rate and power-on pulse timing
  localparam int CLK_MHZ     = 10;
  localparam int POR_MIN_NS  = 100;
  localparam int POR_CYC_RAW = (POR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_MIN_CYC = (POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW;
  localparam int HOLD_W      = 8;

  // Register byte addresses
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] CAUSE_ADDR  = 12'h004;
  localparam logic [11:0] WDT_ADDR    = 12'h008;
  localparam logic [11:0] MONCFG_ADDR = 12'h00C;
  localparam logic [11:0] MONST_ADDR  = 12'h010;

  // Control register fields
  localparam int CTRL_SW_RESET = 0;
  localparam int CTRL_SW_BLOCK = 1;
  localparam int CTRL_WDT_EN   = 2;
  localparam int CTRL_WDT_KICK = 3;

  // Monitor configuration fields
  localparam int MON_ANA_LSB = 0;
  localparam int MON_DIG_LSB = 4;
  localparam int MON_EN_BIT  = 8;

  // Monitor status fields
  localparam int MST_SUP_LSB = 0;
  localparam int MST_ACTIVE  = 3;
  localparam int MST_POR_MON = 4;

  // Low trip codes: 0 is 2.45 V (brownout level), 12 is 5.45 V
  localparam int         TRIP_W        = 4;
  localparam logic [3:0] TRIP_CODE_MAX = 4'hC;
  localparam logic [3:0] TRIP_RST      = 4'h0;

  // Watchdog
  localparam int          WDT_W           = 16;
  localparam logic [15:0] WDT_TIMEOUT_RST = 16'hFFFF;

  // Bus answer constants
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Reset cause flags, one per source
  typedef struct packed {
    logic wdt;
    logic sw;
    logic ext;
    logic por;
  } rsc_cause_t;

  localparam rsc_cause_t CAUSE_NONE = 4'h0;
  localparam rsc_cause_t CAUSE_POR  = 4'h1;
  localparam rsc_cause_t CAUSE_EXT  = 4'h2;
  localparam rsc_cause_t CAUSE_SW   = 4'h4;
  localparam rsc_cause_t CAUSE_WDT  = 4'h8;

  // Supply comparator results and interrupts
  typedef struct packed {
    logic ana_high;
    logic dig_low;
    logic ana_low;
  } rsc_supply_t;

  localparam rsc_supply_t SUPPLY_NONE = 3'h0;

  // Monitor configuration
  typedef struct packed {
    logic       mon_en;
    logic [3:0] dig_trip;
    logic [3:0] ana_trip;
  } rsc_mon_cfg_t;

  localparam rsc_mon_cfg_t MON_CFG_RST = 9'h000;

  // Reset sequencer states
  typedef enum logic [0:0] {
    RSC_HOLD = 1'b0,
    RSC_RUN  = 1'b1
  } rsc_state_t;

endpackage

//--- src/rsc_top.sv
// Reset source controller: merges power-on, external pin, software and
// watchdog resets into one system reset, records the cause, and gates the
// supply monitors. Assumes APB master on pclk; analog comparators outside.
//
// Functional notes
// - System reset output clears processor, peripherals and their registers.
// - Cause of latest reset is kept in a software-readable status register.
// - Power-on reset clears the cause register of older sources.
// - Power-on reset pulse lasts at least 100 ns.
// - Power-on reset stretches while any supply remains below its trip.
// - Power-on monitor turns off when digital supply stable; oscillator starts. Here the oscillator starts once the trip clears, whatever the digital supply.
// - Supply monitors raise an interrupt when a supply leaves its range.
// - Low trip levels 2.45 V to 5.45 V in 250 mV steps.
// - Analog high trip is one fixed 5.75 V level, not programmable.
// - Monitors off until power-on reset done and in sleep or hibernate.
// - External pin low holds reset; response equals a power-on reset. Here watchdog enable and timeout, block bit and monitor config survive it.
// - External reset works in sleep and hibernate, only hibernate exit.
// - Software reset bit, by processor or DMA, resets like power-on. Here watchdog enable and timeout, block bit and monitor config survive it.
// - A control bit blocks the software reset command.
// - Watchdog not restarted within programmed timeout causes a reset.
// - Power-on reset leaves watchdog disabled until firmware enables it.
// - Watchdog enable cannot be cleared except by power-on reset.
// - Watchdog counts only in active mode.
`timescale 1ns/1ps

module rsc_top #(
  parameter int HOLD_CYC = rsc_pkg::POR_MIN_CYC
) (
  // Clock and power-on reset of this block
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Supplies and power mode
  input  wire logic                  supply_below_trip,
  input  wire logic                  digital_supply_stable,
  input  wire logic                  low_power_mode,
  input  wire rsc_pkg::rsc_supply_t  supply_cmp,
  // External reset pin
  input  wire logic                  external_reset_pin_n,
  // Reset and power controls out
  output logic                       system_reset_n,
  output logic                       por_monitor_enable,
  output logic                       main_oscillator_enable,
  output logic                       monitor_enable,
  output logic [3:0]                 ana_trip_sel,
  output logic [3:0]                 dig_trip_sel,
  output rsc_pkg::rsc_supply_t       supply_irq
);

  // Sequencer and source state
  rsc_pkg::rsc_state_t               state;
  rsc_pkg::rsc_state_t               next_state;
  logic [rsc_pkg::HOLD_W-1:0]        hold_cnt;
  logic                              por_src;
  logic                              ext_src;
  logic                              sw_pulse;
  logic                              wdt_pulse;
  logic                              any_src;
  logic                              por_done;

  // Registers
  logic                              sw_block;
  logic                              wdt_en;
  logic [rsc_pkg::WDT_W-1:0]         wdt_timeout;
  logic [rsc_pkg::WDT_W-1:0]         wdt_cnt;
  rsc_pkg::rsc_cause_t               cause;
  rsc_pkg::rsc_cause_t               next_cause;
  rsc_pkg::rsc_mon_cfg_t             mon_cfg;

  // Bus decode
  logic                              setup;
  logic                              wr;
  logic                              mapped;
  logic                              kick;
  logic [31:0]                       next_rdata;
  logic [3:0]                        wr_ana;
  logic [3:0]                        wr_dig;

  // Zero-wait APB: setup registers read data, access completes at once
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == rsc_pkg::CTRL_ADDR)   |
                  (paddr == rsc_pkg::CAUSE_ADDR)  |
                  (paddr == rsc_pkg::WDT_ADDR)    |
                  (paddr == rsc_pkg::MONCFG_ADDR) |
                  (paddr == rsc_pkg::MONST_ADDR);
  assign pslverr = psel & penable & ~mapped;

  // Power-on source: supply below trip keeps it active as long as it lasts
  assign por_src = supply_below_trip;

  // External pin counts at any time, whatever the power mode
  assign ext_src = ~external_reset_pin_n;

  // Software reset command, refused while the block bit is set
  assign sw_pulse = wr & (paddr == rsc_pkg::CTRL_ADDR) &
                    pwdata[rsc_pkg::CTRL_SW_RESET] & ~sw_block;

  // Watchdog restart strobe
  assign kick = wr & (paddr == rsc_pkg::CTRL_ADDR) &
                pwdata[rsc_pkg::CTRL_WDT_KICK];

  assign any_src = por_src | ext_src | sw_pulse | wdt_pulse;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      rsc_pkg::RSC_HOLD:
      begin
        if (!any_src && hold_cnt == '0)
          next_state = rsc_pkg::RSC_RUN;
      end
      rsc_pkg::RSC_RUN:
      begin
        if (any_src)
          next_state = rsc_pkg::RSC_HOLD;
      end
    endcase
  end

  // Sequencer state and stretch counter; reload while any source is active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= rsc_pkg::RSC_HOLD;
      hold_cnt <= rsc_pkg::HOLD_W'(HOLD_CYC);
    end
    else
    begin
      state <= next_state;
      if (any_src)
        hold_cnt <= rsc_pkg::HOLD_W'(HOLD_CYC);
      else if (hold_cnt != '0)
        hold_cnt <= hold_cnt - 1'b1;
    end
  end

  // System reset output, released on a single clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      system_reset_n <= 1'b0;
    else
      system_reset_n <= (next_state == rsc_pkg::RSC_RUN);
  end

  // Power-on completion flag, cleared whenever a supply trips again
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      por_done <= 1'b0;
    else if (por_src)
      por_done <= 1'b0;
    else if (state == rsc_pkg::RSC_RUN)
      por_done <= 1'b1;
  end

  // Power-on monitor on until digital supply is stable and no trip; oscillator on while no trip
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_monitor_enable     <= 1'b1;
      main_oscillator_enable <= 1'b0;
    end
    else
    begin
      por_monitor_enable     <= ~digital_supply_stable | por_src;
      main_oscillator_enable <= ~por_src;
    end
  end

  // Cause capture: on entry to reset, only the winning source is set
  always_comb
  begin
    next_cause = cause;
    if (por_src)
      next_cause = rsc_pkg::CAUSE_POR;
    else if (state == rsc_pkg::RSC_RUN)
    begin
      if (ext_src)
        next_cause = rsc_pkg::CAUSE_EXT;
      else if (wdt_pulse)
        next_cause = rsc_pkg::CAUSE_WDT;
      else if (sw_pulse)
        next_cause = rsc_pkg::CAUSE_SW;
    end
  end

  // Cause register; power-up leaves only the power-on flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause <= rsc_pkg::CAUSE_POR;
    else
      cause <= next_cause;
  end

  // Software reset block bit, kept through non-power-on resets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_block <= 1'b0;
    else if (por_src)
      sw_block <= 1'b0;
    else if (wr && paddr == rsc_pkg::CTRL_ADDR)
      sw_block <= pwdata[rsc_pkg::CTRL_SW_BLOCK];
  end

  // Watchdog enable: set-only, cleared by power-on reset alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_en <= 1'b0;
    else if (por_src)
      wdt_en <= 1'b0;
    else if (wr && paddr == rsc_pkg::CTRL_ADDR &&
             pwdata[rsc_pkg::CTRL_WDT_EN])
      wdt_en <= 1'b1;
  end

  // Watchdog timeout value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_timeout <= rsc_pkg::WDT_TIMEOUT_RST;
    else if (por_src)
      wdt_timeout <= rsc_pkg::WDT_TIMEOUT_RST;
    else if (wr && paddr == rsc_pkg::WDT_ADDR)
      wdt_timeout <= pwdata[rsc_pkg::WDT_W-1:0];
  end

  // Watchdog counter: runs in active mode outside reset, restart clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_cnt   <= '0;
      wdt_pulse <= 1'b0;
    end
    else if (state == rsc_pkg::RSC_HOLD || !wdt_en || kick)
    begin
      wdt_cnt   <= '0;
      wdt_pulse <= 1'b0;
    end
    else if (low_power_mode)
    begin
      wdt_pulse <= 1'b0;
    end
    else if (wdt_cnt >= wdt_timeout)
    begin
      wdt_cnt   <= '0;
      wdt_pulse <= 1'b1;
    end
    else
    begin
      wdt_cnt   <= wdt_cnt + 1'b1;
      wdt_pulse <= 1'b0;
    end
  end

  // Trip codes beyond 5.45 V are refused, the old code is kept
  assign wr_ana = pwdata[rsc_pkg::MON_ANA_LSB +: rsc_pkg::TRIP_W];
  assign wr_dig = pwdata[rsc_pkg::MON_DIG_LSB +: rsc_pkg::TRIP_W];

  // Monitor configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_cfg <= rsc_pkg::MON_CFG_RST;
    else if (por_src)
      mon_cfg <= rsc_pkg::MON_CFG_RST;
    else if (wr && paddr == rsc_pkg::MONCFG_ADDR)
    begin
      mon_cfg.mon_en <= pwdata[rsc_pkg::MON_EN_BIT];
      if (wr_ana <= rsc_pkg::TRIP_CODE_MAX)
        mon_cfg.ana_trip <= wr_ana;
      if (wr_dig <= rsc_pkg::TRIP_CODE_MAX)
        mon_cfg.dig_trip <= wr_dig;
    end
  end

  // Monitor gating and comparator selections; high trip has no selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_enable <= 1'b0;
      ana_trip_sel   <= rsc_pkg::TRIP_RST;
      dig_trip_sel   <= rsc_pkg::TRIP_RST;
    end
    else
    begin
      monitor_enable <= mon_cfg.mon_en & por_done & ~por_src &
                        ~low_power_mode;
      ana_trip_sel   <= mon_cfg.ana_trip;
      dig_trip_sel   <= mon_cfg.dig_trip;
    end
  end

  // Supply interrupts follow comparators while monitoring is enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      supply_irq <= rsc_pkg::SUPPLY_NONE;
    else if (monitor_enable && !low_power_mode)
      supply_irq <= supply_cmp;
    else
      supply_irq <= rsc_pkg::SUPPLY_NONE;
  end

  // Read mux; strobe bits read as zero
  always_comb
  begin
    next_rdata = rsc_pkg::RDATA_ZERO;
    unique case (paddr)
      rsc_pkg::CTRL_ADDR:
      begin
        next_rdata[rsc_pkg::CTRL_SW_BLOCK] = sw_block;
        next_rdata[rsc_pkg::CTRL_WDT_EN]   = wdt_en;
      end
      rsc_pkg::CAUSE_ADDR:
        next_rdata[3:0] = cause;
      rsc_pkg::WDT_ADDR:
        next_rdata[rsc_pkg::WDT_W-1:0] = wdt_timeout;
      rsc_pkg::MONCFG_ADDR:
      begin
        next_rdata[rsc_pkg::MON_ANA_LSB +: rsc_pkg::TRIP_W] = mon_cfg.ana_trip;
        next_rdata[rsc_pkg::MON_DIG_LSB +: rsc_pkg::TRIP_W] = mon_cfg.dig_trip;
        next_rdata[rsc_pkg::MON_EN_BIT] = mon_cfg.mon_en;
      end
      rsc_pkg::MONST_ADDR:
      begin
        next_rdata[rsc_pkg::MST_SUP_LSB +: 3] = supply_irq;
        next_rdata[rsc_pkg::MST_ACTIVE]  = monitor_enable;
        next_rdata[rsc_pkg::MST_POR_MON] = por_monitor_enable;
      end
      default:
        next_rdata = rsc_pkg::RDATA_ZERO;
    endcase
  end

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= rsc_pkg::RDATA_ZERO;
    else if (setup && !pwrite)
      prdata <= next_rdata;
  end

endmodule
